//--- enps_pkg.sv
`default_nettype none
package enps_pkg;
  // ------------------------------------------------------------------
  // Indirect access map.
  // ------------------------------------------------------------------
  localparam logic [7:0] IND_CTRL_HI_ADDR = 8'h6e;
  localparam logic [7:0] IND_CTRL_LO_ADDR = 8'h6f;
  localparam logic [7:0] IND_DATA_ADDR = 8'ha0;
  localparam logic [2:0] TABLE_EEE = 3'h1;
  localparam int TABLE_LSB = 5;
  localparam int PORT_LSB = 0;
  localparam logic [3:0] PORT_MIN = 4'h1;
  localparam logic [3:0] PORT_MAX = 4'h4;
  localparam int NUM_PORTS = 4;
  localparam logic [7:0] PNP_OFFSET = 8'h1b;
  // ------------------------------------------------------------------
  // Field layout and reset value.
  // ------------------------------------------------------------------
  localparam int NP_BIT = 15;
  localparam int ACK_BIT = 14;
  localparam int MP_BIT = 13;
  localparam int ACK2_BIT = 12;
  localparam int TOG_BIT = 11;
  localparam int CODE_MSB = 10;
  localparam logic [15:0] PNP_RESET = 16'h0000;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  typedef struct packed {
    logic next_page;
    logic ack;
    logic msg_page;
    logic ack2;
    logic toggle;
    logic [10:0] code;
  } enps_page_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } enps_bus_t;
endpackage : enps_pkg
`default_nettype wire

//--- enps_page_mem.sv
`default_nettype none
module enps_page_mem #(
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem_ff [DEPTH];
  logic [15:0] nxt_mem [DEPTH];
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      nxt_mem[i] = mem_ff[i];
    end
    if (we) begin
      nxt_mem[waddr] = wdata;
    end
    nxt_rdata = mem_ff[raddr];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= enps_pkg::PNP_RESET;
      end
      rdata_ff <= enps_pkg::PNP_RESET;
    end else begin
      mem_ff <= nxt_mem;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;
endmodule // enps_page_mem
`default_nettype wire

//--- enps_status.sv
// Overview of operation
// [RL1] Bit 15 reports partner next-page follows.
// [RL2] Acknowledge flag always sits at bit 14.
// [RL3] Ack set after three consistent bursts; the partner model sets it on every page.
// [RL4] Bit 13 reports message versus unformatted page.
// [RL5] Bit 12 reports partner acknowledge-2 flag.
// [RL6] Toggle inverts previously exchanged toggle value.
// [RL7] First toggle complements base codeword bit 11.
// [RL8] Bits 10 to 0 hold code field.
// [RL9] Software selects port 1 to 4.
// [RL10] Software selects EEE table with 001.
// [RL11] Value read through indirect byte 0xa0.
// [RL12] Read-only, zero after reset, updated per page.
`default_nettype none
module enps_status #(
  parameter int NPORTS = enps_pkg::NUM_PORTS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire enps_pkg::enps_bus_t bus,
  input wire logic page_valid,
  input wire logic [1:0] page_port,
  input wire enps_pkg::enps_page_t page,
  output logic [7:0] rdata,
  output logic rdata_valid
);
  // ------------------------------------------------------------------
  // Indirect selection state.
  // ------------------------------------------------------------------
  localparam int MEM_AW = 2;
  logic [7:0] ctrl_hi_ff;
  logic [7:0] nxt_ctrl_hi;
  logic [7:0] ctrl_lo_ff;
  logic [7:0] nxt_ctrl_lo;
  logic rd_pend_ff;
  logic nxt_rd_pend;
  logic pend_ok_ff;
  logic nxt_pend_ok;
  logic pend_low_ff;
  logic nxt_pend_low;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic [15:0] word;
  logic sel_ok;
  logic sel_low;
  logic [MEM_AW-1:0] port_idx;
  logic page_we;
  logic [MEM_AW-1:0] page_waddr;
  logic [15:0] page_word;

  // ------------------------------------------------------------------
  // Decoding helpers.
  // ------------------------------------------------------------------
  function automatic logic write_hit(
    input enps_pkg::enps_bus_t b,
    input logic [7:0] a
  );
    write_hit = b.wr && (b.addr == a);
  endfunction

  function automatic logic read_hit(
    input enps_pkg::enps_bus_t b,
    input logic [7:0] a
  );
    read_hit = b.rd && (b.addr == a);
  endfunction

  function automatic logic table_ok(input logic [7:0] hi);
    table_ok = (hi[enps_pkg::TABLE_LSB +: 3] == enps_pkg::TABLE_EEE);
  endfunction

  function automatic logic port_ok(input logic [7:0] hi);
    logic [3:0] p;
    p = hi[enps_pkg::PORT_LSB +: 4];
    port_ok = (p >= enps_pkg::PORT_MIN) && (p <= enps_pkg::PORT_MAX);
  endfunction

  // Both offsets of the pair are accepted; bit 0 then picks the byte.
  function automatic logic offset_ok(input logic [7:0] lo);
    offset_ok = ({lo[7:1], 1'b1} == enps_pkg::PNP_OFFSET);
  endfunction

  function automatic logic selection_ok(
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    selection_ok = table_ok(hi) && port_ok(hi) && offset_ok(lo);
  endfunction

  // Ports are numbered from one; an out-of-range number still maps to a
  // store here, and the refusal comes from selection_ok instead.
  function automatic logic [1:0] port_index(input logic [7:0] hi);
    logic [3:0] p;
    p = hi[enps_pkg::PORT_LSB +: 4] - 4'h1;
    port_index = p[1:0];
  endfunction

  function automatic logic [15:0] pack_page(input enps_pkg::enps_page_t pg);
    pack_page = {pg.next_page, pg.ack, pg.msg_page, pg.ack2, pg.toggle, pg.code};
  endfunction

  function automatic logic [7:0] pick_byte(
    input logic [15:0] w,
    input logic low_half
  );
    pick_byte = low_half ? w[7:0] : w[15:8];
  endfunction

  // ------------------------------------------------------------------
  // Selection registers.
  // ------------------------------------------------------------------
  // The store address follows the port field one cycle late, so the port
  // must be written at least one cycle before the data byte is read.
  assign port_idx = port_index(ctrl_hi_ff);
  assign sel_ok = selection_ok(ctrl_hi_ff, ctrl_lo_ff); // RL9 RL10
  assign sel_low = ctrl_lo_ff[0];

  always_comb begin
    nxt_ctrl_hi = ctrl_hi_ff;
    nxt_ctrl_lo = ctrl_lo_ff;
    if (write_hit(bus, enps_pkg::IND_CTRL_HI_ADDR)) begin
      nxt_ctrl_hi = bus.wdata;
    end
    if (write_hit(bus, enps_pkg::IND_CTRL_LO_ADDR)) begin
      nxt_ctrl_lo = bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_hi_ff <= enps_pkg::CTRL_RESET;
      ctrl_lo_ff <= enps_pkg::CTRL_RESET;
    end else begin
      ctrl_hi_ff <= nxt_ctrl_hi;
      ctrl_lo_ff <= nxt_ctrl_lo;
    end
  end

  // ------------------------------------------------------------------
  // Page store; the link side writes each received page in whole.
  // ------------------------------------------------------------------
  // A received page replaces the stored word for its port, so the flags
  // (next page, ack, message page, ack2, toggle, code) never mix pages.
  always_comb begin
    page_we = page_valid; // RL12
    page_waddr = page_port;
    page_word = pack_page(page); // RL1 RL2 RL4 RL5 RL8
  end

  // The toggle and acknowledge flags are kept exactly as the link side
  // computed them; this block never rewrites a received flag.
  enps_page_mem #(
    .DEPTH(NPORTS),
    .AW(MEM_AW)
  ) u_mem (
    .clk(clk),
    .nrst(nrst),
    .we(page_we),
    .waddr(page_waddr),
    .wdata(page_word), // RL3 RL6 RL7
    .raddr(port_idx),
    .rdata(word)
  );

  // ------------------------------------------------------------------
  // Read request; the selection is captured with the strobe.
  // ------------------------------------------------------------------
  always_comb begin
    nxt_rd_pend = read_hit(bus, enps_pkg::IND_DATA_ADDR); // RL11
    nxt_pend_ok = pend_ok_ff;
    nxt_pend_low = pend_low_ff;
    if (nxt_rd_pend) begin
      nxt_pend_ok = sel_ok;
      nxt_pend_low = sel_low;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_pend_ff <= 1'b0;
      pend_ok_ff <= 1'b0;
      pend_low_ff <= 1'b0;
    end else begin
      rd_pend_ff <= nxt_rd_pend;
      pend_ok_ff <= nxt_pend_ok;
      pend_low_ff <= nxt_pend_low;
    end
  end

  // ------------------------------------------------------------------
  // Read path: memory output lags the select by one cycle, so a read of
  // the data byte answers two cycles after the strobe.
  // ------------------------------------------------------------------
  // A refused selection still answers, with a zero byte, so software
  // never waits on a read that it got slightly wrong.
  always_comb begin
    nxt_rvalid = rd_pend_ff;
    nxt_rdata = rdata_ff;
    if (rd_pend_ff) begin
      if (pend_ok_ff) begin
        nxt_rdata = pick_byte(word, pend_low_ff); // RL1 RL8
      end else begin
        nxt_rdata = 8'h00; // RL9 RL10
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= enps_pkg::RDATA_RESET;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // ------------------------------------------------------------------
  // Outputs.
  // ------------------------------------------------------------------
  assign rdata = rdata_ff;
  assign rdata_valid = rvalid_ff; // RL12
endmodule // enps_status
`default_nettype wire

//--- enps_status_checker.sv
`default_nettype none
module enps_status_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire enps_pkg::enps_bus_t bus,
  input wire logic page_valid,
  input wire logic [1:0] page_port,
  input wire enps_pkg::enps_page_t page,
  input wire logic [7:0] rdata,
  input wire logic rdata_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rd; bus.rd && bus.addr == 8'ha0; endsequence
  sequence s_hi(d); bus.wr && bus.addr == 8'h6e && bus.wdata == d; endsequence
  sequence s_pg(o);
    page_valid && page_port == 2'h0 ##1 s_hi(8'h21) ##1
    bus.wr && bus.addr == 8'h6f && bus.wdata == o ##1 s_rd;
  endsequence
  property p_ans; s_rd |-> ##2 rdata_valid; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_why; rdata_valid |-> $past(bus.rd, 2) && $past(bus.addr, 2) == 8'ha0; endproperty
  a_why: assert property (p_why) else $error("stray answer");
  property p_hold; !rdata_valid |-> $stable(rdata); endproperty
  a_hold: assert property (p_hold) else $error("byte moved");
  property p_rst; $rose(nrst) |-> rdata == 8'h00 && !rdata_valid; endproperty
  a_rst: assert property (p_rst) else $error("not clear");
  property p_tbl; s_hi(8'h41) ##1 s_rd |-> ##2 rdata == 8'h00; endproperty
  a_tbl: assert property (p_tbl) else $error("table");
  property p_port; s_hi(8'h25) ##1 s_rd |-> ##2 rdata == 8'h00; endproperty
  a_port: assert property (p_port) else $error("port");
  property p_up; s_pg(8'h1a) |-> ##2 rdata == $past(page[15:8], 5); endproperty
  a_up: assert property (p_up) else $error("flags");
  property p_low; s_pg(8'h1b) |-> ##2 rdata == $past(page[7:0], 5); endproperty
  a_low: assert property (p_low) else $error("code");
endmodule // enps_status_checker
bind enps_status enps_status_checker i_chk (.clk(clk), .nrst(nrst), .bus(bus),
  .page_valid(page_valid), .page_port(page_port), .page(page), .rdata(rdata),
  .rdata_valid(rdata_valid));
`default_nettype wire

//--- enps_partner.sv
`default_nettype none
module enps_partner #(parameter logic BASE_TOG = 1'b0) (
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] info,
  output logic page_valid,
  output enps_pkg::enps_page_t page
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog = ~BASE_TOG;
  initial page_valid = 1'b0;
  initial page = '0;
  // Ack is always set: a page leaves on every go pulse, with no burst matching.
  always @(posedge clk) begin
    page_valid <= go;
    if (go) begin
      page <= {info[15], 1'b1, info[13:12], tog, info[10:0]};
      tog <= ~tog;
    end
  end
endmodule // enps_partner
`default_nettype wire

//--- enps_status_test.sv
`default_nettype none
module enps_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic [1:0] port = 2'h0;
  logic [15:0] info = 16'h0000;
  enps_pkg::enps_bus_t bus = '0;
  logic pv;
  enps_pkg::enps_page_t page;
  logic [7:0] rdata;
  logic rv;
  logic [7:0] q[$];
  logic [7:0] bad[3] = '{8'h41, 8'h25, 8'h20};
  int err_total = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  enps_partner i_lp (.clk(clk), .go(go), .info(info), .page_valid(pv), .page(page));
  enps_status i_dut (.clk(clk), .nrst(nrst), .bus(bus), .page_valid(pv), .page_port(port),
    .page(page), .rdata(rdata), .rdata_valid(rv));
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    bus = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk) #1;
  endtask
  task automatic rd(input logic [7:0] e);
    q.push_back(e);
    op(1'b0, 8'ha0, 8'h00);
  endtask
  task automatic sel(input logic [7:0] c, input logic [7:0] o);
    op(1'b1, 8'h6e, c);
    op(1'b1, 8'h6f, o);
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rv === 1'b1 && q.size() == 0) begin
      err_total++;
      $display("mismatch %0t exp %h got %h", $time, 8'h00, rdata);
    end else if (rv === 1'b1) begin
      chk(q.pop_front(), rdata);
    end
  end
  initial begin
    void'($urandom(32'hde5e));
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    sel(8'h21, 8'h1a);
    rd(8'h00);
    for (int p = 1; p <= 4; p++) begin
      for (int o = 0; o < 2; o++) begin
        // A fresh page before each read keeps the toggle moving.
        bus = '0;
        info = 16'($urandom);
        port = 2'(p - 1);
        go = 1'b1;
        @(posedge clk) #1;
        go = 1'b0;
        @(posedge clk) #1;
        sel({3'h1, 1'b0, 4'(p)}, 8'h1a + 8'(o));
        rd(o ? page[7:0] : page[15:8]);
      end
    end
    foreach (bad[i]) begin
      op(1'b1, 8'h6e, bad[i]);
      rd(8'h00);
    end
    sel(8'h21, 8'h1c);
    rd(8'h00);
    bus = '0;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b0;
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    sel(8'h21, 8'h1b);
    rd(8'h00);
    bus = '0;
    repeat (10) @(posedge clk);
    if (q.size() != 0) err_total++;
    stop_test();
  end
endmodule // enps_status_test
`default_nettype wire
